// ===== flash_dprot_cmd_object_regs_tb.sv
// self-checking bench for the flash protection and command object registers
`default_nettype none
module flash_dprot_cmd_object_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, se;
  logic [7:0] paddr = 8'h0, cfg_dp = 8'h0, cfg_op = 8'h0, opt_bits;
  logic [31:0] pwd = 32'h0, prdata, rd;
  logic cfg_ld = 1'b0, dp_dbf = 1'b0, op_dbf = 1'b0, done = 1'b0, start;
  flash_regs_pkg::cmd_req_t req;
  flash_regs_pkg::cmd_res_t res = '0;
  int err_total = 0, n_tests = 0, starts = 0;
  // size 7 protects eight 256-byte units from the base
  localparam logic [17:0] PROT_END = flash_regs_pkg::DFLASH_BASE + 18'h800;
  flash_dprot_cmd_regs DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PSTRB_IN(4'h1), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .CFG_LOAD_IN(cfg_ld), .CFG_DPROT_IN(cfg_dp),
    .CFG_DPROT_DBF_IN(dp_dbf), .CFG_OPT_IN(cfg_op), .CFG_OPT_DBF_IN(op_dbf),
    .CMD_START_OUT(start), .CMD_REQ_OUT(req), .CMD_RES_IN(res), .CMD_DONE_IN(done),
    .OPTION_BITS_OUT(opt_bits));
  always #5 clk = ~clk;
  // count start pulses so checks never race the pulse edge
  always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [4:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= {1'b0, idx, 2'h0};
    pwd   <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 16) begin
      err_total++;
      stop_test();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rd_chk(input logic [4:0] i, input logic [7:0] exp);
    apb(1'b0, i, 8'h0);
    chk(rd, {24'h0, exp});
  endtask
  task automatic load(input logic [7:0] dp, input logic [7:0] op, input logic f);
    cfg_ld <= 1'b1;
    cfg_dp <= dp;
    cfg_op <= op;
    dp_dbf <= f;
    op_dbf <= f;
    @(posedge clk);
    cfg_ld <= 1'b0;
    @(posedge clk);
  endtask
  // fill words 0 and 1, then launch through the status register
  task automatic setcmd(input logic [7:0] code, input logic [17:0] a);
    wr(flash_regs_pkg::IDX_CMD_IDX, 8'h0);
    wr(flash_regs_pkg::IDX_CMD_HI, code);
    wr(flash_regs_pkg::IDX_CMD_LO, {6'h0, a[17:16]});
    wr(flash_regs_pkg::IDX_CMD_IDX, 8'h1);
    wr(flash_regs_pkg::IDX_CMD_HI, a[15:8]);
    wr(flash_regs_pkg::IDX_CMD_LO, a[7:0]);
    wr(flash_regs_pkg::IDX_STATUS, 8'h80);
  endtask
  // controller writes a result into word 2, then reports completion
  task automatic finish();
    res <= '{1'b1, 3'h2, 16'hbeef};
    @(posedge clk);
    res.we <= 1'b0;
    done   <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_load();
    rd_chk(flash_regs_pkg::IDX_STATUS, 8'h80);
    load(8'h80, 8'h00, 1'b1);
    rd_chk(flash_regs_pkg::IDX_DPROT, 8'h0f);
    rd_chk(flash_regs_pkg::IDX_OPT, 8'hff);
    chk({24'h0, opt_bits}, 32'h0000_00ff);
    load(8'h83, 8'h5a, 1'b0);
    rd_chk(flash_regs_pkg::IDX_DPROT, 8'h83);
    wr(flash_regs_pkg::IDX_OPT, 8'h00);
    rd_chk(flash_regs_pkg::IDX_OPT, 8'h5a);
    chk({24'h0, opt_bits}, 32'h0000_005a);
    $display("load test done");
  endtask
  task automatic t_obj();
    for (int i = 0; i < 8; i++) begin
      wr(flash_regs_pkg::IDX_CMD_IDX, 8'(i));
      wr(flash_regs_pkg::IDX_CMD_HI, 8'h10 + 8'(i));
      wr(flash_regs_pkg::IDX_CMD_LO, 8'h20 + 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      wr(flash_regs_pkg::IDX_CMD_IDX, 8'(i));
      rd_chk(flash_regs_pkg::IDX_CMD_HI, i < 6 ? 8'h10 + 8'(i) : 8'h00);
      rd_chk(flash_regs_pkg::IDX_CMD_LO, i < 6 ? 8'h20 + 8'(i) : 8'h00);
    end
    $display("object test done");
  endtask
  task automatic t_launch();
    setcmd(flash_regs_pkg::CMD_PROG_DF, flash_regs_pkg::DFLASH_BASE);
    rd_chk(flash_regs_pkg::IDX_STATUS, 8'h00);
    chk(starts, 1);
    chk({6'h0, req.command_code, req.addr},
        {6'h0, flash_regs_pkg::CMD_PROG_DF, flash_regs_pkg::DFLASH_BASE});
    chk(req.data[31:0], 32'h1323_1222);
    wr(flash_regs_pkg::IDX_CMD_HI, 8'hff);
    finish();
    rd_chk(flash_regs_pkg::IDX_STATUS, 8'h80);
    rd_chk(flash_regs_pkg::IDX_CMD_HI, 8'h44);
    wr(flash_regs_pkg::IDX_CMD_IDX, 8'h2);
    rd_chk(flash_regs_pkg::IDX_CMD_HI, 8'hbe);
    rd_chk(flash_regs_pkg::IDX_CMD_LO, 8'hef);
    $display("launch test done");
  endtask
  task automatic t_prot();
    logic [7:0] wv[4] = '{8'h05, 8'h85, 8'h03, 8'h07};
    logic [7:0] ev[4] = '{8'h05, 8'h05, 8'h05, 8'h07};
    for (int i = 0; i < 4; i++) begin
      wr(flash_regs_pkg::IDX_DPROT, wv[i]);
      rd_chk(flash_regs_pkg::IDX_DPROT, ev[i]);
    end
    $display("protection test done");
  endtask
  task automatic t_viol();
    logic [7:0] cv[3] = '{flash_regs_pkg::CMD_PROG_DF, flash_regs_pkg::CMD_ERASE_DF,
                          flash_regs_pkg::CMD_ERASE_BLOCK};
    for (int i = 0; i < 3; i++) begin
      setcmd(cv[i], i == 0 ? PROT_END - 18'h1 : flash_regs_pkg::DFLASH_BASE);
      rd_chk(flash_regs_pkg::IDX_STATUS, 8'h90);
      wr(flash_regs_pkg::IDX_STATUS, 8'h10);
      chk(starts, 1);
    end
    setcmd(flash_regs_pkg::CMD_PROG_DF, PROT_END);
    finish();
    rd_chk(flash_regs_pkg::IDX_STATUS, 8'h80);
    chk(starts, 2);
    $display("violation test done");
  endtask
  task automatic t_rsvd();
    for (logic [4:0] i = 5'h0c; i <= 5'h13; i++) begin
      wr(i, 8'hff);
      if (i != flash_regs_pkg::IDX_OPT) rd_chk(i, 8'h00);
    end
    apb(1'b0, 5'h00, 8'h0);
    chk({31'h0, se}, 32'h1);
    $display("reserved test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_load();
    t_obj();
    t_launch();
    t_prot();
    t_viol();
    t_rsvd();
    stop_test();
  end
endmodule
`default_nettype wire

// ===== flash_dprot_cmd_regs.sv
// data-flash protection, command object and option registers on apb
// bus behaviour
// - every register is one aligned word, byte lane 0 only
// - byte address is four times the register index
// - upper address bits above the map must be zero
// - misaligned or unmapped words raise the error response
// - an errored write changes nothing at all
// - read data is captured in the setup cycle
// - ready rises in the first access cycle, no wait states
// - a write lands at the edge that ends the access cycle
// - strobe lane 0 low turns any write into a no-op
// - that includes the launch write to the status word
//
// reset and configuration load
// - asynchronous reset gives full protection as a safe default
// - option bits read all ones until the load pulse arrives
// - the load pulse may come at any time after reset release
// - a double fault on a byte takes the fail-safe value instead
// - the load pulse wins over a bus write in the same cycle
// - reserved protection bits 6 to 4 always read zero
//
// protection register
// - open bit set: any written value is accepted
// - open bit clear: open bit must stay clear
// - open bit clear: size may stay or grow, never shrink
// - an equal size write is accepted and changes nothing
// - a write that lowers anything is dropped as a whole
// - partial acceptance was rejected to keep software simple
// - size step is one 256 byte unit from the base
// - size code fifteen covers the whole data flash
//
// command object
// - six sixteen bit words behind one index register
// - high and low bytes are written and read separately
// - index six and seven: writes vanish, reads give zero
// - the index register itself stays writable while busy
// - so software may read results as soon as the flag sets
// - object writes while a command runs are dropped
// - the controller may write result words only while busy
// - result writes while idle are ignored
//
// command launch
// - writing one to the complete flag launches a command
// - the launch is only taken while the flag reads one
// - a launch while busy is silently ignored
// - the start pulse lasts one cycle, one edge after the write
// - the request bus is simply the object words, no copy
// - this saves a 90 bit holding register; the lock keeps it stable
// - completion from the controller sets the flag again
// - completion while idle is ignored
//
// refusals
// - program or sector erase inside the protected range
// - block erase of data flash while any sector is protected
// - a refused launch gives no start pulse
// - the complete flag stays set so software may retry
// - the violation flag is set instead
// - violation clears by writing one to its bit
// - a set and a clear in one cycle: the set wins
// - so a refusal is never lost to a racing clear
//
// option register
// - no bus write path exists at all
// - only the load pulse may change it
// - its value is also driven to the system as a port
//
// factory reserved words
// - all of them read zero
// - every write is accepted on the bus and discarded
// - no error response, so test software sees a plain slave
//
// limits
// - only the commands that touch data flash are decoded here
// - other command codes always launch unchecked
// - access and mode errors belong to the controller
// - the clock divider setup lives outside this block
// - there is no interrupt; software polls the flag
//
// hazards
// - never write the object while busy; it is dropped silently
// - load the configuration once after every reset
// - the request bus is only meaningful while busy
// - result words overwrite the request words in place
// - the start pulse is registered to keep the request settled
// - read data stands until the next setup cycle
//
// timing summary
// - write access: two cycles, setup and access
// - read access: two cycles, data held from setup
// - launch to start pulse: one cycle
// - completion to flag set: one cycle
// - refusal to violation flag: one cycle
`default_nettype none
module flash_dprot_cmd_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                      CLK_IN,
  input  wire logic                      ARST_N_IN,
  // apb slave
  input  wire logic                      PSEL_IN,
  input  wire logic                      PENABLE_IN,
  input  wire logic                      PWRITE_IN,
  input  wire logic [ADDR_W-1:0]         PADDR_IN,
  input  wire logic [31:0]               PWDATA_IN,
  input  wire logic [3:0]                PSTRB_IN,
  output logic                           PREADY_OUT,
  output logic [31:0]                    PRDATA_OUT,
  output logic                           PSLVERR_OUT,
  // configuration load from program flash at the reset sequence
  input  wire logic                      CFG_LOAD_IN,
  input  wire logic [7:0]                CFG_DPROT_IN,
  input  wire logic                      CFG_DPROT_DBF_IN,
  input  wire logic [7:0]                CFG_OPT_IN,
  input  wire logic                      CFG_OPT_DBF_IN,
  // memory controller
  output logic                           CMD_START_OUT,
  output flash_regs_pkg::cmd_req_t       CMD_REQ_OUT,
  input  wire flash_regs_pkg::cmd_res_t  CMD_RES_IN,
  input  wire logic                      CMD_DONE_IN,
  // option bits to the system
  output logic [7:0]                     OPTION_BITS_OUT
);
  initial begin
    if (ADDR_W < 7) $error("ADDR_W must reach index 0x13");
  end

  logic [7:0]  dprot_reg;
  logic [7:0]  opt_reg;
  logic [2:0]  cmd_idx_reg;
  logic [15:0] cmd_obj_reg [0:5];
  logic        cmd_complete_flag_reg;
  logic        viol_reg;
  logic        start_reg;
  logic [31:0] prdata_reg;
  logic        slverr_reg;

  // bus decode; byte lane 0 carries all 8-bit registers
  logic [4:0] reg_idx;
  logic       setup_ph;
  logic       wr_acc;
  logic       wr_b0;
  logic       mapped;
  assign reg_idx  = PADDR_IN[6:2];
  assign setup_ph = PSEL_IN & ~PENABLE_IN;
  assign wr_acc   = PSEL_IN & PENABLE_IN & PWRITE_IN & ~slverr_reg;
  assign wr_b0    = wr_acc & PSTRB_IN[0];

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [4:0] i;
    i = a[6:2];
    is_mapped = (a[1:0] == 2'h0) && ((a >> 7) == '0) &&
                (i == flash_regs_pkg::IDX_CMD_IDX || i == flash_regs_pkg::IDX_STATUS ||
                 (i >= flash_regs_pkg::IDX_DPROT && i <= flash_regs_pkg::IDX_RSV7));
  endfunction
  assign mapped = is_mapped(PADDR_IN);

  // protection range check; open bit set protects nothing
  function automatic logic in_prot(input logic [7:0] p, input logic [17:0] a);
    logic [17:0] top;
    top = flash_regs_pkg::DFLASH_BASE +
          ({14'h0, p[3:0]} << flash_regs_pkg::DPROT_UNIT_LOG2) +
          ((18'h1 << flash_regs_pkg::DPROT_UNIT_LOG2) - 18'h1);
    in_prot = ~p[flash_regs_pkg::DPROT_OPEN_BIT] &&
              a >= flash_regs_pkg::DFLASH_BASE && a <= top;
  endfunction

  function automatic logic in_dflash(input logic [17:0] a);
    in_dflash = a >= flash_regs_pkg::DFLASH_BASE && a <= flash_regs_pkg::DFLASH_LAST;
  endfunction

  // assemble the command from the object words
  flash_regs_pkg::cmd_req_t req;
  assign req.command_code = cmd_obj_reg[0][15:8];
  assign req.addr         = {cmd_obj_reg[0][1:0], cmd_obj_reg[1]};
  assign req.data         = {cmd_obj_reg[5], cmd_obj_reg[4], cmd_obj_reg[3],
                             cmd_obj_reg[2]};
  assign CMD_REQ_OUT      = req;

  // refuse commands that would alter protected data flash
  logic refuse;
  always_comb begin
    refuse = 1'b0;
    if ((req.command_code == flash_regs_pkg::CMD_PROG_DF ||
         req.command_code == flash_regs_pkg::CMD_ERASE_DF) && in_prot(dprot_reg, req.addr))
      refuse = 1'b1;
    if (req.command_code == flash_regs_pkg::CMD_ERASE_BLOCK && in_dflash(req.addr) &&
        ~dprot_reg[flash_regs_pkg::DPROT_OPEN_BIT])
      refuse = 1'b1;
  end

  // launch request: software writes one to the complete flag while idle
  logic launch;
  assign launch = wr_b0 && reg_idx == flash_regs_pkg::IDX_STATUS &&
                  PWDATA_IN[flash_regs_pkg::STAT_CMD_COMPLETE_FLAG_BIT] && cmd_complete_flag_reg;

  // protection write acceptance: only ever adds protection
  function automatic logic dprot_ok(input logic [7:0] cur, input logic [7:0] nw);
    if (cur[flash_regs_pkg::DPROT_OPEN_BIT])
      dprot_ok = 1'b1;
    else
      dprot_ok = ~nw[flash_regs_pkg::DPROT_OPEN_BIT] && nw[3:0] >= cur[3:0];
  endfunction

  // protection register; full protection until the configuration is loaded
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dprot_reg <= flash_regs_pkg::DPROT_FULL;
    end else if (CFG_LOAD_IN) begin
      if (CFG_DPROT_DBF_IN)
        dprot_reg <= flash_regs_pkg::DPROT_FULL;
      else
        dprot_reg <= CFG_DPROT_IN & 8'h8f;
    end else if (wr_b0 && reg_idx == flash_regs_pkg::IDX_DPROT &&
                 dprot_ok(dprot_reg, PWDATA_IN[7:0])) begin
      dprot_reg <= PWDATA_IN[7:0] & 8'h8f;
    end
  end

  // option register; no bus write path exists
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      opt_reg <= flash_regs_pkg::OPT_FAULT;
    end else if (CFG_LOAD_IN) begin
      opt_reg <= CFG_OPT_DBF_IN ? flash_regs_pkg::OPT_FAULT : CFG_OPT_IN;
    end
  end
  assign OPTION_BITS_OUT = opt_reg;

  // index register selects the object word
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_idx_reg <= flash_regs_pkg::CMD_IDX_RST;
    end else if (wr_b0 && reg_idx == flash_regs_pkg::IDX_CMD_IDX) begin
      cmd_idx_reg <= PWDATA_IN[2:0];
    end
  end

  // object words: software writes while idle, controller results while busy
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < 6; i++) cmd_obj_reg[i] <= 16'h0000;
    end else if (!cmd_complete_flag_reg) begin
      if (CMD_RES_IN.we && CMD_RES_IN.index < flash_regs_pkg::CMD_WORDS)
        cmd_obj_reg[CMD_RES_IN.index] <= CMD_RES_IN.data;
    end else if (wr_b0 && cmd_idx_reg < flash_regs_pkg::CMD_WORDS) begin
      if (reg_idx == flash_regs_pkg::IDX_CMD_HI)
        cmd_obj_reg[cmd_idx_reg][15:8] <= PWDATA_IN[7:0];
      if (reg_idx == flash_regs_pkg::IDX_CMD_LO)
        cmd_obj_reg[cmd_idx_reg][7:0] <= PWDATA_IN[7:0];
    end
  end

  // complete flag: clear on launch, set by controller completion
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_complete_flag_reg <= 1'b1;
    end else if (CMD_DONE_IN && !cmd_complete_flag_reg) begin
      cmd_complete_flag_reg <= 1'b1;
    end else if (launch && !refuse) begin
      cmd_complete_flag_reg <= 1'b0;
    end
  end

  // violation flag: a refused launch sets it, set beats a write-one clear
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      viol_reg <= 1'b0;
    end else if (launch && refuse) begin
      viol_reg <= 1'b1;
    end else if (wr_b0 && reg_idx == flash_regs_pkg::IDX_STATUS &&
                 PWDATA_IN[flash_regs_pkg::STAT_VIOL_BIT]) begin
      viol_reg <= 1'b0;
    end
  end

  // one-cycle start pulse to the controller
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= launch && !refuse;
    end
  end
  assign CMD_START_OUT = start_reg;

  // read mux; reserved and unmapped words return zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (reg_idx)
      flash_regs_pkg::IDX_STATUS:
        rd_byte = {cmd_complete_flag_reg, 2'h0, viol_reg, 4'h0};
      flash_regs_pkg::IDX_CMD_IDX: rd_byte = {5'h00, cmd_idx_reg};
      flash_regs_pkg::IDX_DPROT:   rd_byte = dprot_reg;
      flash_regs_pkg::IDX_CMD_HI:
        if (cmd_idx_reg < flash_regs_pkg::CMD_WORDS)
          rd_byte = cmd_obj_reg[cmd_idx_reg][15:8];
      flash_regs_pkg::IDX_CMD_LO:
        if (cmd_idx_reg < flash_regs_pkg::CMD_WORDS)
          rd_byte = cmd_obj_reg[cmd_idx_reg][7:0];
      flash_regs_pkg::IDX_OPT:     rd_byte = opt_reg;
      default:                     rd_byte = 8'h00;
    endcase
  end

  // read data and error are captured in the setup phase, so both are registered
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg <= mapped ? {24'h000000, rd_byte} : 32'h0000_0000;
      slverr_reg <= ~mapped;
    end
  end

  // one access cycle, no extra wait states
  assign PREADY_OUT  = PSEL_IN & PENABLE_IN;
  assign PRDATA_OUT  = prdata_reg;
  assign PSLVERR_OUT = slverr_reg & PSEL_IN & PENABLE_IN;
endmodule
`default_nettype wire

// ===== flash_regs_pkg.sv
// shared constants and types for the flash register block
`default_nettype none
package flash_regs_pkg;
  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_STATUS   = 5'h06;
  localparam logic [4:0] IDX_CMD_IDX  = 5'h01;
  localparam logic [4:0] IDX_DPROT    = 5'h09;
  localparam logic [4:0] IDX_CMD_HI   = 5'h0a;
  localparam logic [4:0] IDX_CMD_LO   = 5'h0b;
  localparam logic [4:0] IDX_RSV1     = 5'h0c;
  localparam logic [4:0] IDX_RSV2     = 5'h0d;
  localparam logic [4:0] IDX_RSV3     = 5'h0e;
  localparam logic [4:0] IDX_RSV4     = 5'h0f;
  localparam logic [4:0] IDX_OPT      = 5'h10;
  localparam logic [4:0] IDX_RSV5     = 5'h11;
  localparam logic [4:0] IDX_RSV6     = 5'h12;
  localparam logic [4:0] IDX_RSV7     = 5'h13;
  // field positions
  localparam int DPROT_OPEN_BIT  = 7;
  localparam int STAT_CMD_COMPLETE_FLAG_BIT   = 7;
  localparam int STAT_VIOL_BIT   = 4;
  // reset and fail-safe values
  localparam logic [7:0] DPROT_FULL  = 8'h0f;
  localparam logic [7:0] OPT_FAULT   = 8'hff;
  localparam logic [2:0] CMD_IDX_RST = 3'h0;
  localparam logic [2:0] CMD_WORDS   = 3'h6;
  // data-flash geometry
  localparam logic [17:0] DFLASH_BASE  = 18'h04400;
  localparam logic [17:0] DFLASH_LAST  = 18'h053ff;
  localparam int          DPROT_UNIT_LOG2 = 8;
  // command codes that alter data flash
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_PROG_DF     = 8'h11;
  localparam logic [7:0] CMD_ERASE_DF    = 8'h12;
  // command handed to the memory controller
  typedef struct packed {
    logic [7:0]  command_code;
    logic [17:0] addr;
    logic [63:0] data;
  } cmd_req_t;
  // result write-back from the memory controller
  typedef struct packed {
    logic        we;
    logic [2:0]  index;
    logic [15:0] data;
  } cmd_res_t;
endpackage
`default_nettype wire

// ===== flash_regs_sva.sv
// assertion checker for the flash protection and command object registers
`default_nettype none
module flash_regs_sva #(
  parameter int ADDR_W = 8
) (
  // apb side
  input wire logic                     CLK_IN,
  input wire logic                     ARST_N_IN,
  input wire logic                     PSEL_IN,
  input wire logic                     PENABLE_IN,
  input wire logic                     PWRITE_IN,
  input wire logic [ADDR_W-1:0]        PADDR_IN,
  input wire logic [31:0]              PRDATA_OUT,
  // configuration and controller side
  input wire logic                     CFG_LOAD_IN,
  input wire logic [7:0]               CFG_OPT_IN,
  input wire logic                     CFG_OPT_DBF_IN,
  input wire logic                     CMD_START_OUT,
  input wire flash_regs_pkg::cmd_req_t CMD_REQ_OUT,
  input wire flash_regs_pkg::cmd_res_t CMD_RES_IN,
  input wire logic                     CMD_DONE_IN,
  input wire logic [7:0]               OPTION_BITS_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic busy_reg;
  logic st_wr;
  logic rsv_rd;
  // status write seen on the bus; start may lag it by one or two edges
  assign st_wr  = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN[6:0] == 7'h18;
  assign rsv_rd = PSEL_IN && PENABLE_IN && !PWRITE_IN && PADDR_IN[1:0] == 2'h0 &&
                  PADDR_IN[6:2] inside {5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13};
  // running command; result write-back is the only legal object change then
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) busy_reg <= 1'b0;
    else if (CMD_START_OUT) busy_reg <= 1'b1;
    else if (CMD_DONE_IN) busy_reg <= 1'b0;
  end
  a_start_pulse: assert property (CMD_START_OUT |=> !CMD_START_OUT)
    else $error("start pulse longer than one cycle");
  a_start_idle: assert property (CMD_START_OUT |-> !busy_reg)
    else $error("start while a command runs");
  a_start_cause: assert property (CMD_START_OUT |-> $past(st_wr) || $past(st_wr, 2))
    else $error("start without a status write");
  a_req_locked: assert property (
    busy_reg && !CMD_START_OUT && !$past(CMD_RES_IN.we) |-> $stable(CMD_REQ_OUT))
    else $error("command object changed while locked");
  a_opt_load: assert property (CFG_LOAD_IN |=>
    OPTION_BITS_OUT == ($past(CFG_OPT_DBF_IN) ? 8'hff : $past(CFG_OPT_IN)))
    else $error("option byte load wrong");
  a_opt_ro: assert property (!CFG_LOAD_IN |=> $stable(OPTION_BITS_OUT))
    else $error("option byte changed without load");
  a_rsvd_zero: assert property (rsv_rd |-> PRDATA_OUT == 32'h0)
    else $error("reserved register read nonzero");
  a_rdata_byte: assert property (PRDATA_OUT[31:8] == 24'h0)
    else $error("read data above byte lane");
  c_start: cover property (CMD_START_OUT);
  c_done: cover property (busy_reg && CMD_DONE_IN);
  c_dbf: cover property (CFG_LOAD_IN && CFG_OPT_DBF_IN);
endmodule
bind flash_dprot_cmd_regs flash_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
  .CFG_LOAD_IN(CFG_LOAD_IN), .CFG_OPT_IN(CFG_OPT_IN), .CFG_OPT_DBF_IN(CFG_OPT_DBF_IN),
  .CMD_START_OUT(CMD_START_OUT), .CMD_REQ_OUT(CMD_REQ_OUT), .CMD_RES_IN(CMD_RES_IN),
  .CMD_DONE_IN(CMD_DONE_IN), .OPTION_BITS_OUT(OPTION_BITS_OUT));
`default_nettype wire
